// *** rtl/gap_pkg.sv ***
package gap_pkg;

  localparam int GAP_PINS = 12;

  // pin positions of the alternate roles
  localparam int PIN_SER_DIN = 0;
  localparam int PIN_SER_CLK = 1;
  localparam int PIN_SER_DOUT = 2;
  localparam int PIN_SEL0 = 3;
  localparam int PIN_SEL1_GLS = 4;
  localparam int PIN_PARK = 8;
  localparam int PIN_RC = 10;
  localparam int PIN_THERM_PWR = 11;

  // pins that act only as inputs in their alternate role
  localparam logic [11:0] ALT_INPUT_MASK = 12'h101;
  // strap pins sampled during boot
  localparam logic [11:0] STRAP_MASK = 12'h006;

  localparam int CLK_PERIOD_NS = 8;
  localparam int BOOT_SAMPLE_NS = 1000;
  localparam logic [7:0] BOOT_CYCLES = 8'((BOOT_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [2:0] LANES_RESET = 3'h1;

  typedef enum logic [1:0] {
    GAP_MODE_IN = 2'h0,
    GAP_MODE_OUT = 2'h1,
    GAP_MODE_BIDIR = 2'h2,
    GAP_MODE_OD = 2'h3
  } gap_mode_e;

  typedef enum logic [1:0] {
    GAP_ST_BOOT = 2'h1,
    GAP_ST_RUN = 2'h2
  } gap_state_e;

  // straps {upper, lower}: 00..11 give 1..4 lanes
  function automatic logic [2:0] gap_lane_decode(input logic [1:0] strap);
    gap_lane_decode = {1'b0, strap} + 3'h1;
  endfunction

endpackage

// *** rtl/gap_pin_cell.sv ***
`timescale 1ns/1ps
module gap_pin_cell
  import gap_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] mode,
  input wire logic use_alt,
  input wire logic alt_out,
  input wire logic alt_drive,
  input wire logic sw_out,
  input wire logic sw_drive,
  input wire logic force_in,
  output logic pin_out,
  output logic pin_oe_n
);

  typedef struct packed {
    logic out;
    logic oe_n;
  } gap_cell_s;

  gap_cell_s s;
  gap_cell_s next_s;

  always_comb begin
    next_s.out = 1'b0;
    next_s.oe_n = 1'b1;
    if (force_in) begin
      next_s.oe_n = 1'b1;
    // [R2] alternate role wins
    end else if (use_alt) begin
      next_s.out = alt_out;
      next_s.oe_n = !alt_drive;
    end else begin
      // [R1] four software modes
      case (gap_mode_e'(mode))
        GAP_MODE_IN: next_s.oe_n = 1'b1;
        GAP_MODE_OUT: begin
          next_s.out = sw_out;
          next_s.oe_n = 1'b0;
        end
        GAP_MODE_BIDIR: begin
          next_s.out = sw_out;
          next_s.oe_n = !sw_drive;
        end
        // open drain only ever pulls low; the pullup is external
        GAP_MODE_OD: next_s.oe_n = sw_out;
        default: next_s.oe_n = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '{out: 1'b0, oe_n: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign pin_out = s.out;
  assign pin_oe_n = s.oe_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_od_never_high: assert property ( // [R1]
    !$past(force_in) && !$past(use_alt) && $past(mode) == GAP_MODE_OD |-> !pin_out && pin_oe_n == $past(sw_out))
    else $error("open drain pin drove high or missed a low");
  a_alt_drive: assert property ( // [R2]
    !$past(force_in) && $past(use_alt) |-> pin_out == $past(alt_out) && pin_oe_n == !$past(alt_drive))
    else $error("alternate role not reflected on pin");
  a_out_mode: assert property ( // [R1]
    !$past(force_in) && !$past(use_alt) && $past(mode) == GAP_MODE_OUT |-> !pin_oe_n && pin_out == $past(sw_out))
    else $error("output mode pin not driven");

endmodule

// *** rtl/gap_port.sv ***
// Overview of operation
// [R1] every pin can be set by software as input, output, bidirectional or open-drain.
// [R2] a per-pin select picks the plain role or the alternate role of that pin.
// [R3] during boot the two strap pins are sampled and 00,01,10,11 give 1,2,3,4 lanes.
// [R4] after boot sampling the strap pins return to serial data out and serial clock.
// [R5] a low park request input makes the block ask for the mirror array to park, not power down.
// [R6] the host keeps the park request high at power-up until the interrupt output has gone low.
// [R7] in glasses mode the pin drives 1 for the left shutter and 0 for the right.
// [R8] one pin may carry the optional active-low second serial select as an output.
// [R9] one pin carries the active-low first serial select output.
// [R10] one pin carries the serial data input from the power management device.
// [R11] one pin in its alternate role carries the serial data output.
// [R12] one pin in its alternate role carries the serial clock output.
// [R13] thermistor power is on only while the thermistor is in use and enabled.
// [R14] an alternate pin drives the thermistor therm_rc_drive network.
// [R15] unused pins are best set by software as outputs driving zero.
// [R16] the lane count is latched once at the end of boot and held until reset.
`timescale 1ns/1ps
module gap_port
  import gap_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [11:0] pin_in,
  output logic [11:0] pin_out,
  output logic [11:0] pin_oe_n,
  input wire logic [23:0] pin_mode,
  input wire logic [11:0] pin_alt_sel,
  input wire logic glasses_select,
  input wire logic [11:0] gpio_out_val,
  input wire logic [11:0] gpio_drive,
  output logic [11:0] gpio_in,
  input wire logic aux_serial_clock,
  input wire logic aux_serial_data_out,
  input wire logic aux_serial_select_0_n,
  input wire logic aux_serial_select_1_n,
  output logic aux_serial_data_in,
  input wire logic glasses_left,
  input wire logic therm_in_use,
  input wire logic therm_enable,
  input wire logic therm_rc_drive,
  output logic park_mirrors,
  output logic boot_done,
  output logic [2:0] lane_count
);

  typedef struct packed {
    gap_state_e state;
    logic [7:0] cnt;
    logic [2:0] lanes;
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic park;
  } gap_port_s;

  gap_port_s s;
  gap_port_s next_s;
  logic [11:0] alt_out;
  logic [11:0] alt_drive;
  logic in_boot;

  assign in_boot = (s.state == GAP_ST_BOOT);

  always_comb begin
    alt_out = 12'h000;
    alt_drive = ~ALT_INPUT_MASK;
    // [R12] serial clock out
    alt_out[PIN_SER_CLK] = aux_serial_clock;
    // [R11] serial data out
    alt_out[PIN_SER_DOUT] = aux_serial_data_out;
    // [R9] first select out
    alt_out[PIN_SEL0] = aux_serial_select_0_n;
    // [R7] [R8] glasses or second select
    alt_out[PIN_SEL1_GLS] = glasses_select ? glasses_left : aux_serial_select_1_n;
    // [R14] therm_rc_drive drive
    alt_out[PIN_RC] = therm_rc_drive;
    // [R13] thermistor power gate
    alt_out[PIN_THERM_PWR] = therm_in_use & therm_enable;
  end

  // [R1] [R2] [R15] per pin drive
  for (genvar i = 0; i < GAP_PINS; i++) begin : g_pin
    gap_pin_cell u_cell (
      .clk(clk),
      .reset(reset),
      .mode(pin_mode[2*i +: 2]),
      .use_alt(pin_alt_sel[i]),
      .alt_out(alt_out[i]),
      .alt_drive(alt_drive[i]),
      .sw_out(gpio_out_val[i]),
      .sw_drive(gpio_drive[i]),
      .force_in(in_boot & STRAP_MASK[i]),
      .pin_out(pin_out[i]),
      .pin_oe_n(pin_oe_n[i])
    );
  end

  always_comb begin
    next_s = s;
    next_s.sync1 = pin_in;
    next_s.sync2 = s.sync1;
    case (s.state)
      GAP_ST_BOOT: begin
        // [R3] [R16] sample straps once, then hand pins back
        if (s.cnt == BOOT_CYCLES - 8'h01) begin
          next_s.lanes = gap_lane_decode({s.sync2[PIN_SER_DOUT], s.sync2[PIN_SER_CLK]});
          next_s.state = GAP_ST_RUN;
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
      GAP_ST_RUN: next_s.state = GAP_ST_RUN;
      default: next_s.state = GAP_ST_BOOT;
    endcase
    // [R5] [R6] park on low, ignored until boot ends
    next_s.park = (s.state == GAP_ST_RUN) && pin_alt_sel[PIN_PARK] && !s.sync2[PIN_PARK];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '{state: GAP_ST_BOOT, cnt: 8'h00, lanes: LANES_RESET, sync1: 12'h000, sync2: 12'h000, park: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign gpio_in = s.sync2;
  // [R10] serial data in
  assign aux_serial_data_in = s.sync2[PIN_SER_DIN];
  assign park_mirrors = s.park;
  assign boot_done = (s.state == GAP_ST_RUN);
  assign lane_count = s.lanes;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_straps_released: assert property ( // [R3]
    in_boot |-> pin_oe_n[PIN_SER_CLK] && pin_oe_n[PIN_SER_DOUT])
    else $error("strap pin driven during boot");
  a_lane_latch: assert property ( // [R3]
    $rose(boot_done) |-> lane_count == gap_lane_decode({$past(s.sync2[PIN_SER_DOUT]), $past(s.sync2[PIN_SER_CLK])}))
    else $error("lane count does not match straps");
  a_lane_hold: assert property ( // [R16]
    boot_done && $past(boot_done) |-> $stable(lane_count))
    else $error("lane count changed after boot");
  a_boot_length: assert property ( // [R16]
    $fell(reset) |-> !boot_done [*8])
    else $error("boot ended too early");
  a_serial_return: assert property ( // [R4]
    $past(boot_done) && $past(pin_alt_sel[PIN_SER_CLK])
      |-> !pin_oe_n[PIN_SER_CLK] && pin_out[PIN_SER_CLK] == $past(aux_serial_clock))
    else $error("strap pin not back on serial clock");
  a_park_request: assert property ( // [R5]
    boot_done && pin_alt_sel[PIN_PARK] && !s.sync2[PIN_PARK] |=> park_mirrors)
    else $error("park request missed");
  a_park_idle: assert property ( // [R5]
    !boot_done || s.sync2[PIN_PARK] |=> !park_mirrors)
    else $error("park without request");
  a_glasses_eye: assert property ( // [R7]
    $past(boot_done) && $past(pin_alt_sel[PIN_SEL1_GLS]) && $past(glasses_select)
      |-> pin_out[PIN_SEL1_GLS] == $past(glasses_left))
    else $error("glasses eye level wrong");
  a_therm_power: assert property ( // [R13]
    $past(pin_alt_sel[PIN_THERM_PWR]) |-> pin_out[PIN_THERM_PWR] == ($past(therm_in_use) && $past(therm_enable)))
    else $error("thermistor power wrong");
  a_select_zero: assert property ( // [R9]
    $past(pin_alt_sel[PIN_SEL0]) |-> !pin_oe_n[PIN_SEL0] && pin_out[PIN_SEL0] == $past(aux_serial_select_0_n))
    else $error("first select not driven");
  a_data_in: assert property ( // [R10]
    aux_serial_data_in == $past(pin_in[PIN_SER_DIN], 2))
    else $error("serial data in latency wrong");

endmodule

// *** dv/gap_pads_model.sv ***
`timescale 1ns/1ps
module gap_pads_model
  import gap_pkg::*;
(
  input wire logic [11:0] pin_out,
  input wire logic [11:0] pin_oe_n,
  input wire logic [11:0] ext_level,
  output logic [11:0] pin_in
);
  // released pins show the pull, host or pmic level, never the last drive
  // straps, park, pmic data
  always_comb begin
    for (int i = 0; i < GAP_PINS; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
endmodule

// *** dv/test_gap_port.sv ***
`timescale 1ns/1ps
module test_gap_port
  import gap_pkg::*;
;
  logic clk = 0, reset = 1, gl_sel = 0, s_clk = 0, s_do = 0, s0_n = 1, s1_n = 1, gl_l = 0;
  logic t_use = 0, t_en = 0, t_rc = 0, s_di, park, boot_done;
  logic [11:0] alt = 0, g_val = 0, g_drv = 0, ext = 12'h100, pin_in, pin_out, pin_oe_n, gpio_in;
  logic [23:0] mode = 0;
  logic [2:0] lane_count;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  always #4 clk = ~clk;
  gap_port u_gap_port(.clk(clk), .reset(reset), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_mode(mode), .pin_alt_sel(alt), .glasses_select(gl_sel), .gpio_out_val(g_val), .gpio_drive(g_drv),
    .gpio_in(gpio_in), .aux_serial_clock(s_clk), .aux_serial_data_out(s_do), .aux_serial_select_0_n(s0_n),
    .aux_serial_select_1_n(s1_n), .aux_serial_data_in(s_di), .glasses_left(gl_l), .therm_in_use(t_use),
    .therm_enable(t_en), .therm_rc_drive(t_rc), .park_mirrors(park), .boot_done(boot_done),
    .lane_count(lane_count));
  gap_pads_model u_gap_pads_model(.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext), .pin_in(pin_in));
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task at(input int n);
    repeat (n) @(posedge clk);
  endtask
  task end_sim;
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task t_boot;
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      @(posedge clk);
      reset <= 1;
      ext[2:1] <= s;
      alt <= 12'h006;
      mode <= 24'h000014;
      at(2);
      reset <= 0;
      at(60);
      @(negedge clk);
      chk(pin_oe_n[2:1] === 2'b11 && boot_done === 1'b0 && lane_count === 3'h1, "boot pins");
      for (int n = 0; n < 200 && boot_done !== 1'b1; n++) @(negedge clk);
      chk(lane_count === {1'b0, s} + 3'h1, "lane count");
      @(posedge clk);
      ext[2:1] <= ~s;
      s_clk <= 1;
      s_do <= 0;
      at(3);
      @(negedge clk);
      chk(lane_count === {1'b0, s} + 3'h1, "lane moved");
      chk(pin_oe_n[2:1] === 2'b00 && pin_out[2:1] === 2'b01, "serial pins");
    end
    $display("boot test done");
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      alt <= 0;
      mode[11:10] <= m[1:0];
      g_val[5] <= 1;
      g_drv[5] <= 1;
      ext[5] <= 0;
      at(3);
      @(negedge clk);
      chk(pin_oe_n[5] === m[0] ~^ m[1] && gpio_in[5] === (m[0] ^ m[1]), "mode");
      if (m != 0) chk(pin_out[5] === (m != 3), "mode value");
    end
    @(posedge clk);
    mode[11:10] <= 2'h1;
    g_val[5] <= 0;
    at(2);
    @(negedge clk);
    chk(pin_oe_n[5] === 1'b0 && pin_out[5] === 1'b0, "unused zero");
    $display("mode test done");
  endtask
  task t_alt;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      alt <= 12'hd1f;
      mode <= 24'h555555;
      gl_sel <= 0;
      {s_clk, s0_n, t_rc, t_en, ext[0]} <= {5{i[0]}};
      {s_do, s1_n} <= {2{~i[0]}};
      t_use <= 1;
      at(3);
      @(negedge clk);
      chk(pin_out[4:1] === {~i[0], i[0], ~i[0], i[0]} && pin_oe_n[4:1] === 4'h0, "serial out");
      chk(pin_out[11:10] === {2{i[0]}} && pin_oe_n[11:10] === 2'h0, "therm");
      chk(s_di === i[0] && pin_oe_n[0] === 1'b1, "data in");
      @(posedge clk);
      gl_sel <= 1;
      gl_l <= i[0];
      at(3);
      @(negedge clk);
      chk(pin_out[4] === i[0] && pin_oe_n[4] === 1'b0, "glasses");
    end
    $display("alt test done");
  endtask
  task t_park;
    @(posedge clk);
    ext[8] <= 0;
    at(2);
    @(negedge clk);
    chk(park === 1'b0, "park early");
    @(negedge clk);
    chk(park === 1'b1, "park");
    @(posedge clk);
    ext[8] <= 1;
    at(3);
    @(negedge clk);
    chk(park === 1'b0, "unpark");
    $display("park test done");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim;
    end
  end
  initial begin
    t_boot;
    t_modes;
    t_alt;
    t_park;
    end_sim;
  end
endmodule
